/* File: dpsp_pkg.sv */
package dpsp_pkg;

  // frame geometry, counted in shift-clock rising edges
  localparam int unsigned     CNT_W           = 6;
  localparam logic [5:0]      CNT_RESET       = 6'h00;
  localparam logic [5:0]      CNT_STEP        = 6'h01;
  localparam logic [5:0]      EDGE_FIRST      = 6'h01;
  localparam logic [5:0]      LEG_DATA_FIRST  = 6'h08;
  localparam logic [5:0]      LEG_DATA_LAST   = 6'h1f;
  localparam logic [5:0]      FRAME_LAST      = 6'h20;

  // legacy header position in the shifter just before the first data edge
  localparam int unsigned     LEG_RW_POS      = 6;
  localparam int unsigned     LEG_ADDR_MSB    = 5;

  // register 0 fields
  localparam logic [4:0]      ID_REG_ADDR     = 5'h00;
  localparam int unsigned     PTR_MSB         = 4;
  localparam int unsigned     SWRST_BIT       = 5;
  localparam logic [4:0]      PTR_RESET       = 5'h00;
  localparam logic [23:0]     DATA_ZERO       = 24'h00_0000;
  localparam logic [23:0]     OPEN_STROBE_MASK = 24'hff_ffc0;
  localparam logic [23:0]     LEG_STROBE_MASK  = 24'hff_ffdf;

  // identity and chip address defaults; the id value is arbitrary
  localparam logic [23:0]     CHIP_ID_DEFAULT   = 24'h12_3456;
  localparam logic [2:0]      CHIP_ADDR_DEFAULT = 3'h0;

  typedef enum logic [1:0] {
    MODE_LISTEN,
    MODE_LEGACY,
    MODE_OPEN
  } dpsp_mode_type;

  typedef struct packed {
    logic [23:0] frame_payload;
    logic [4:0]  frame_register_address;
    logic [2:0]  frame_chip_address;
  } dpsp_open_frame_type;

  typedef struct packed {
    logic        read_flag;
    logic [5:0]  frame_register_address;
    logic [23:0] frame_payload;
  } dpsp_legacy_frame_type;

  typedef struct packed {
    logic [4:0]  reg_addr;
    logic [23:0] reg_data;
  } dpsp_write_type;

endpackage

/* File: dpsp_serial_port.sv */
`timescale 1ns/1ps
// Function
// - first enable rise legacy, first clock rise open
// - chosen protocol stays until power reset
// - legacy first bit: low write, high read
// - legacy six address bits on edges 2-7
// - legacy write data on edges 8-31
// - legacy read drives 24 bits, edges 8-31
// - lock indicator restored at 32nd rising edge
// - open frame starts with 24 data bits
// - open register address on edges 25-29
// - open chip address on edges 30-32
// - open frame latched on enable rising edge
// - open cycles output register at read pointer
// - open readback drives data until enable rises
// - foreign chip address releases data-out pin
// - register 0 write: soft reset, strobes; pointer loaded by open writes only
// - register 0 reads return chip identification
// - soft reset bit restores register defaults
module dpsp_serial_port #(
  parameter logic [23:0] CHIP_ID   = dpsp_pkg::CHIP_ID_DEFAULT,
  parameter logic [2:0]  CHIP_ADDR = dpsp_pkg::CHIP_ADDR_DEFAULT
) (
  // system clock and power reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     sys_rst_in,
  // serial link pins
  input  wire logic                     sck_in,
  input  wire logic                     serial_port_enable_in,
  input  wire logic                     serial_data_in_in,
  output wire logic                     serial_data_out_out,
  output wire logic                     serial_data_out_oe_n_out,
  // device side
  input  wire logic                     lock_indicator_in,
  output dpsp_pkg::dpsp_mode_type       mode_out,
  output logic                          cfg_wr_valid_out,
  output dpsp_pkg::dpsp_write_type      cfg_wr_out,
  output logic                          soft_reset_out,
  output logic                          strobe_valid_out,
  output logic [23:0]                   strobe_bits_out,
  output logic [4:0]                    read_pointer_out
);

  function automatic logic [23:0] read_value(input logic [5:0] addr);
    read_value = (addr == {1'b0, dpsp_pkg::ID_REG_ADDR}) ? CHIP_ID : dpsp_pkg::DATA_ZERO;
  endfunction

  // ---------------- system clock domain ----------------
  logic                            sen_meta_reg;
  logic                            sen_sync_reg;
  logic                            sen_prev_reg;
  logic                            sck_meta_reg;
  logic                            sck_sync_reg;
  logic                            sck_prev_reg;
  logic                            tog_meta_reg;
  logic                            tog_sync_reg;
  logic                            tog_prev_reg;
  logic                            lock_reg;
  logic                            sen_rise;
  logic                            sck_rise;
  logic                            leg_done;
  dpsp_pkg::dpsp_mode_type         mode_reg;
  logic [4:0]                      ptr_reg;
  logic                            commit;
  dpsp_pkg::dpsp_write_type        commit_word;
  logic                            commit_open;

  // ---------------- link clock domain ----------------
  logic                            lrst_meta_reg;
  logic                            lrst_reg;
  dpsp_pkg::dpsp_mode_type         lmode_meta_reg;
  dpsp_pkg::dpsp_mode_type         lmode_reg;
  logic [dpsp_pkg::CNT_W-1:0]      cnt_reg;
  logic [dpsp_pkg::CNT_W-1:0]      cnt_next;
  logic [31:0]                     shift_reg;
  dpsp_pkg::dpsp_legacy_frame_type leg_word_reg;
  logic                            leg_tog_reg;
  logic [23:0]                     out_reg;
  logic                            drv_reg;
  logic                            open_seen_reg;
  logic                            mismatch_reg;
  logic                            edge_legacy;
  logic                            accept;
  logic                            open_sel;
  dpsp_pkg::dpsp_open_frame_type   open_frame;

  always_ff @(posedge sys_clk_in) begin
    sen_meta_reg <= serial_port_enable_in;
    sen_sync_reg <= sen_meta_reg;
    sck_meta_reg <= sck_in;
    sck_sync_reg <= sck_meta_reg;
    tog_meta_reg <= leg_tog_reg;
    tog_sync_reg <= tog_meta_reg;
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      sen_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      tog_prev_reg <= 1'b0;
      lock_reg     <= 1'b0;
    end else begin
      sen_prev_reg <= sen_sync_reg;
      sck_prev_reg <= sck_sync_reg;
      tog_prev_reg <= tog_sync_reg;
      lock_reg     <= lock_indicator_in;
    end
  end

  assign sen_rise = sen_sync_reg && !sen_prev_reg;
  assign sck_rise = sck_sync_reg && !sck_prev_reg;
  assign leg_done = tog_sync_reg != tog_prev_reg;

  // protocol choice; only the power reset clears it
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      mode_reg <= dpsp_pkg::MODE_LISTEN;
    end else if (mode_reg == dpsp_pkg::MODE_LISTEN) begin
      if (sen_rise) begin
        mode_reg <= dpsp_pkg::MODE_LEGACY;
      end else if (sck_rise) begin
        mode_reg <= dpsp_pkg::MODE_OPEN;
      end
    end
  end

  // frame words are quiet here: the link clock is idle around the enable edge
  assign open_frame  = shift_reg;
  assign commit_open = (mode_reg == dpsp_pkg::MODE_OPEN) && sen_rise &&
                       (open_frame.frame_chip_address == CHIP_ADDR);

  always_comb begin
    commit      = 1'b0;
    commit_word = '0;
    if (commit_open) begin
      commit      = 1'b1;
      commit_word = {open_frame.frame_register_address, open_frame.frame_payload};
    end else if ((mode_reg == dpsp_pkg::MODE_LEGACY) && leg_done && !leg_word_reg.read_flag &&
                 !leg_word_reg.frame_register_address[5]) begin
      commit      = 1'b1;
      commit_word = {leg_word_reg.frame_register_address[4:0], leg_word_reg.frame_payload};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ptr_reg          <= dpsp_pkg::PTR_RESET;
      soft_reset_out   <= 1'b0;
      strobe_valid_out <= 1'b0;
      strobe_bits_out  <= dpsp_pkg::DATA_ZERO;
      cfg_wr_valid_out <= 1'b0;
      cfg_wr_out       <= '0;
    end else begin
      soft_reset_out   <= 1'b0;
      strobe_valid_out <= 1'b0;
      cfg_wr_valid_out <= 1'b0;
      if (commit && (commit_word.reg_addr == dpsp_pkg::ID_REG_ADDR)) begin
        strobe_valid_out <= 1'b1;
        strobe_bits_out  <= commit_word.reg_data &
                            (commit_open ? dpsp_pkg::OPEN_STROBE_MASK : dpsp_pkg::LEG_STROBE_MASK);
        if (commit_word.reg_data[dpsp_pkg::SWRST_BIT]) begin
          soft_reset_out <= 1'b1;
          ptr_reg        <= dpsp_pkg::PTR_RESET;
        end else if (commit_open) begin
          ptr_reg <= commit_word.reg_data[dpsp_pkg::PTR_MSB:0];
        end
      end else if (commit) begin
        cfg_wr_valid_out <= 1'b1;
        cfg_wr_out       <= commit_word;
      end
    end
  end

  assign mode_out         = mode_reg;
  assign read_pointer_out = ptr_reg;

  // ---------------- link clock logic ----------------
  always_ff @(posedge sck_in) begin
    lrst_meta_reg  <= sys_rst_in;
    lrst_reg       <= lrst_meta_reg;
    lmode_meta_reg <= mode_reg;
    lmode_reg      <= lmode_meta_reg;
  end

  // enable high at a clock edge marks legacy traffic, low marks open traffic
  assign edge_legacy = serial_port_enable_in;
  assign accept      = (lmode_reg == dpsp_pkg::MODE_LISTEN) ||
                       ((lmode_reg == dpsp_pkg::MODE_LEGACY) == edge_legacy);
  assign cnt_next    = (cnt_reg == dpsp_pkg::FRAME_LAST) ? dpsp_pkg::EDGE_FIRST :
                       cnt_reg + dpsp_pkg::CNT_STEP;

  always_ff @(posedge sck_in) begin
    if (lrst_reg) begin
      cnt_reg   <= dpsp_pkg::CNT_RESET;
      shift_reg <= '0;
    end else if (accept) begin
      cnt_reg   <= cnt_next;
      shift_reg <= {shift_reg[30:0], serial_data_in_in};
    end
  end

  // completed legacy frame handed over by toggle
  always_ff @(posedge sck_in) begin
    if (lrst_reg) begin
      leg_word_reg <= '0;
      leg_tog_reg  <= 1'b0;
    end else if (accept && edge_legacy && (cnt_next == dpsp_pkg::LEG_DATA_LAST)) begin
      leg_word_reg <= {shift_reg[29:0], serial_data_in_in};
      leg_tog_reg  <= !leg_tog_reg;
    end
  end

  // read shifter: loads at the first data edge, then moves one bit per edge
  always_ff @(posedge sck_in) begin
    if (lrst_reg) begin
      out_reg <= dpsp_pkg::DATA_ZERO;
    end else if (accept && edge_legacy && (cnt_next == dpsp_pkg::LEG_DATA_FIRST)) begin
      out_reg <= read_value(shift_reg[dpsp_pkg::LEG_ADDR_MSB:0]);
    end else if (accept && !edge_legacy && (cnt_next == dpsp_pkg::EDGE_FIRST)) begin
      out_reg <= read_value({1'b0, ptr_reg});
    end else if (accept) begin
      out_reg <= {out_reg[22:0], 1'b0};
    end
  end

  always_ff @(posedge sck_in) begin
    if (lrst_reg) begin
      drv_reg <= 1'b0;
    end else if (accept && edge_legacy) begin
      if (cnt_next == dpsp_pkg::LEG_DATA_FIRST) begin
        drv_reg <= shift_reg[dpsp_pkg::LEG_RW_POS];
      end else if (cnt_next == dpsp_pkg::FRAME_LAST) begin
        drv_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sck_in) begin
    if (lrst_reg) begin
      open_seen_reg <= 1'b0;
      mismatch_reg  <= 1'b0;
    end else if (accept && !edge_legacy) begin
      open_seen_reg <= 1'b1;
      if (cnt_next == dpsp_pkg::FRAME_LAST) begin
        mismatch_reg <= {shift_reg[1:0], serial_data_in_in} != CHIP_ADDR;
      end else if (cnt_next == dpsp_pkg::EDGE_FIRST) begin
        mismatch_reg <= 1'b0;
      end
    end
  end

  // pin mux: legacy read data during a read, open data whenever enable is low after the first open edge, lock indicator otherwise
  assign open_sel                 = open_seen_reg && !serial_port_enable_in;
  assign serial_data_out_out      = (drv_reg || open_sel) ? out_reg[23] : lock_reg;
  assign serial_data_out_oe_n_out = mismatch_reg;

  // ---------------- checks ----------------
  a_mode_sticky: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (mode_reg != dpsp_pkg::MODE_LISTEN) |=> (mode_reg == $past(mode_reg)))
    else $error("protocol choice changed after selection");

  a_legacy_choice: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (mode_reg == dpsp_pkg::MODE_LISTEN) && sen_rise |=> (mode_reg == dpsp_pkg::MODE_LEGACY))
    else $error("enable rise did not select legacy");

  a_open_choice: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    (mode_reg == dpsp_pkg::MODE_LISTEN) && !sen_rise && sck_rise |=> (mode_reg == dpsp_pkg::MODE_OPEN))
    else $error("clock rise did not select open");

  a_swrst_keeps: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    soft_reset_out |-> (ptr_reg == dpsp_pkg::PTR_RESET) && (mode_reg == $past(mode_reg, 2)))
    else $error("soft reset touched protocol or left pointer");

  a_ptr_load: assert property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    commit_open && (open_frame.frame_register_address == dpsp_pkg::ID_REG_ADDR) &&
    !open_frame.frame_payload[dpsp_pkg::SWRST_BIT]
    |=> (ptr_reg == $past(open_frame.frame_payload[dpsp_pkg::PTR_MSB:0])) && strobe_valid_out)
    else $error("open write to register 0 did not set pointer");

  a_id_load: assert property (@(posedge sck_in) disable iff (lrst_reg)
    accept && edge_legacy && (cnt_next == dpsp_pkg::LEG_DATA_FIRST) &&
    (shift_reg[dpsp_pkg::LEG_ADDR_MSB:0] == 6'h00) |=> (out_reg == CHIP_ID))
    else $error("register 0 read did not return chip id");

  a_leg_window: assert property (@(posedge sck_in) disable iff (lrst_reg)
    drv_reg |-> (cnt_reg >= dpsp_pkg::LEG_DATA_FIRST) && (cnt_reg <= dpsp_pkg::LEG_DATA_LAST))
    else $error("legacy read driven outside edges 8 to 31");

  a_leg_release: assert property (@(posedge sck_in) disable iff (lrst_reg)
    accept && edge_legacy && (cnt_next == dpsp_pkg::FRAME_LAST) |=> !drv_reg ##0
    (serial_data_out_out == lock_reg))
    else $error("lock indicator not restored at edge 32");

  a_leg_msb: assert property (@(posedge sck_in) disable iff (lrst_reg)
    drv_reg && (cnt_reg == dpsp_pkg::LEG_DATA_FIRST) |-> ##1 drv_reg [*8])
    else $error("legacy read dropped early");

  a_foreign_chip: assert property (@(posedge sck_in) disable iff (lrst_reg)
    accept && !edge_legacy && (cnt_next == dpsp_pkg::FRAME_LAST) &&
    ({shift_reg[1:0], serial_data_in_in} != CHIP_ADDR) |=> serial_data_out_oe_n_out)
    else $error("foreign chip address left pin driven");

  c_legacy_read: cover property (@(posedge sck_in) disable iff (lrst_reg)
    drv_reg && (cnt_reg == dpsp_pkg::LEG_DATA_LAST));
  c_legacy_write: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    commit && (mode_reg == dpsp_pkg::MODE_LEGACY));
  c_open_commit: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in)
    commit_open && !open_frame.frame_payload[dpsp_pkg::SWRST_BIT]);
  c_soft_reset: cover property (@(posedge sys_clk_in) disable iff (sys_rst_in) soft_reset_out);

endmodule

/* File: dpsp_host_model.sv */
`timescale 1ns/1ps
module dpsp_host_model (
  // link pins
  output logic     sck_out,
  output logic     en_out,
  output logic     sdi_out,
  input  wire logic sdo_in,
  input  wire logic oe_n_in
);
  localparam time HALF = 32;
  logic last_q;
  // a released pin shows the inverse of its last driven level
  wire sdo_w = oe_n_in ? ~last_q : sdo_in;
  initial begin
    sck_out = 1'b0;
    en_out  = 1'b0;
    sdi_out = 1'b0;
    last_q  = 1'b0;
  end
  always @(sdo_in or oe_n_in) begin
    if (oe_n_in === 1'b0) last_q = sdo_in;
  end
  // lone enable pulse, no clock: claims legacy mode after power reset
  task automatic select_legacy;
    #HALF en_out = 1'b1;
    #HALF en_out = 1'b0;
  endtask
  task automatic pulses(input int n);
    repeat (n) begin
      #HALF sck_out = 1'b1;
      #HALF sck_out = 1'b0;
    end
  endtask
  task automatic legacy(input logic rw, input logic [5:0] a, input logic [23:0] d, output logic [23:0] q);
    logic [30:0] bits;
    bits = {rw, a, d};
    q = 24'h00_0000;
    #HALF en_out = 1'b1;
    sdi_out = bits[30];
    for (int i = 1; i <= 32; i++) begin
      #HALF sck_out = 1'b1;
      #HALF sck_out = 1'b0;
      if (i >= 8 && i <= 31) q = {q[22:0], sdo_w};
      if (i <= 30) sdi_out = bits[30-i];
      if (i == 32) en_out = 1'b0;
    end
    sdi_out = 1'b0;
    #HALF;
  endtask
  task automatic open(input logic [23:0] d, input logic [4:0] r, input logic [2:0] c,
                      output logic [23:0] q, output logic lk);
    logic [31:0] bits;
    bits = {d, r, c};
    q = 24'h00_0000;
    for (int i = 0; i < 32; i++) begin
      sdi_out = bits[31-i];
      #HALF sck_out = 1'b1;
      #HALF sck_out = 1'b0;
      if (i < 24) q = {q[22:0], sdo_w};
    end
    sdi_out = 1'b0;
    #HALF en_out = 1'b1;
    #104 lk = sdo_w;
    en_out = 1'b0;
    #104;
  endtask
endmodule

/* File: dpsp_serial_port_tb.sv */
`timescale 1ns/1ps
module dpsp_serial_port_tb;
  logic                     clk;
  logic                     rst;
  logic                     lock;
  wire                      sck;
  wire                      en;
  wire                      serial_data_in;
  wire                      serial_data_out;
  wire                      oe_n;
  dpsp_pkg::dpsp_mode_type  mode_out;
  logic                     cfg_wr_valid_out;
  dpsp_pkg::dpsp_write_type cfg_wr_out;
  logic                     soft_reset_out;
  logic                     strobe_valid_out;
  logic [23:0]              strobe_bits_out;
  logic [4:0]               read_pointer_out;
  logic [23:0]              q;
  logic                     lk;
  int                       fails;
  int                       n_compared;
  int                       cyc;
  int                       n_cfg;
  int                       n_srst;
  int                       n_stb;
  int                       base;
  int                       b_stb;

  dpsp_serial_port u_dpsp_serial_port (.sys_clk_in(clk), .sys_rst_in(rst), .sck_in(sck),
    .serial_port_enable_in(en), .serial_data_in_in(serial_data_in), .serial_data_out_out(serial_data_out),
    .serial_data_out_oe_n_out(oe_n), .lock_indicator_in(lock), .mode_out(mode_out),
    .cfg_wr_valid_out(cfg_wr_valid_out), .cfg_wr_out(cfg_wr_out), .soft_reset_out(soft_reset_out),
    .strobe_valid_out(strobe_valid_out), .strobe_bits_out(strobe_bits_out),
    .read_pointer_out(read_pointer_out));
  dpsp_host_model u_dpsp_host_model (.sck_out(sck), .en_out(en), .sdi_out(serial_data_in), .sdo_in(serial_data_out),
    .oe_n_in(oe_n));

  initial clk = 1'b0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cfg_wr_valid_out === 1'b1) n_cfg++;
    if (soft_reset_out === 1'b1) n_srst++;
    if (strobe_valid_out === 1'b1) n_stb++;
    if (cyc == 30000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim;
    if (fails == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask
  // two clock pulses after release let the link-side reset synchroniser drain
  // before the first real frame; in legacy the enable pulse claims the mode first
  task automatic do_reset(input logic legacy_sel);
    @(posedge clk) #1 rst = 1'b1;
    u_dpsp_host_model.pulses(3);
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    repeat (3) @(posedge clk);
    if (legacy_sel) begin
      u_dpsp_host_model.select_legacy();
      repeat (4) @(posedge clk);
    end
    u_dpsp_host_model.pulses(2);
    repeat (4) @(posedge clk);
  endtask

  task automatic t_legacy_select;
    do_reset(1'b1);
    base = n_cfg;
    u_dpsp_host_model.legacy(1'b0, 6'h03, 24'ha5_5a3c, q);
    check(mode_out === dpsp_pkg::MODE_LEGACY, "legacy not chosen");
    check(n_cfg == base + 1, "legacy write lost");
    check(cfg_wr_out === {5'h03, 24'ha5_5a3c}, "legacy write content");
    u_dpsp_host_model.pulses(4);
    check(mode_out === dpsp_pkg::MODE_LEGACY, "legacy mode changed");
  endtask
  task automatic t_legacy_reg0;
    base = n_srst;
    b_stb = n_stb;
    u_dpsp_host_model.legacy(1'b0, 6'h00, 24'hff_ffff, q);
    check(n_srst == base + 1, "no soft reset");
    check(n_stb == b_stb + 1, "no strobe pulse");
    check(strobe_bits_out === (24'hff_ffff & dpsp_pkg::LEG_STROBE_MASK), "legacy strobes");
    check(mode_out === dpsp_pkg::MODE_LEGACY, "soft reset changed mode");
    base = n_cfg;
    u_dpsp_host_model.legacy(1'b0, 6'h20, 24'h00_0011, q);
    check(n_cfg == base, "out of range write taken");
  endtask
  task automatic t_legacy_read;
    @(posedge clk) #1 lock = 1'b1;
    u_dpsp_host_model.legacy(1'b1, 6'h00, 24'h00_0000, q);
    check(q === dpsp_pkg::CHIP_ID_DEFAULT, "id read");
    check(serial_data_out === 1'b1, "lock not restored");
    u_dpsp_host_model.legacy(1'b1, 6'h03, 24'h00_0000, q);
    check(q === 24'h00_0000, "unmapped read");
  endtask
  task automatic t_open_read;
    do_reset(1'b0);
    u_dpsp_host_model.open(24'h00_0003, 5'h00, 3'h0, q, lk);
    check(mode_out === dpsp_pkg::MODE_OPEN, "open not chosen");
    check(read_pointer_out === 5'h03, "pointer write");
    u_dpsp_host_model.open(24'h00_0000, 5'h00, 3'h0, q, lk);
    check(q === 24'h00_0000, "reg 3 readback");
    check(lk === lock, "lock during enable high");
    u_dpsp_host_model.open(24'h00_0000, 5'h00, 3'h0, q, lk);
    check(q === dpsp_pkg::CHIP_ID_DEFAULT, "id readback");
    check(mode_out === dpsp_pkg::MODE_OPEN, "open mode changed");
  endtask
  task automatic t_open_write;
    base = n_cfg;
    u_dpsp_host_model.open(24'h12_3400, 5'h07, 3'h0, q, lk);
    check(n_cfg == base + 1 && cfg_wr_out === {5'h07, 24'h12_3400}, "open write");
    u_dpsp_host_model.open(24'h55_5555, 5'h09, 3'h5, q, lk);
    check(n_cfg == base + 1, "foreign frame taken");
    check(oe_n === 1'b1, "pin not released");
    base = n_srst;
    u_dpsp_host_model.open(24'hff_ff23, 5'h00, 3'h0, q, lk);
    check(n_srst == base + 1 && read_pointer_out === 5'h00, "open soft reset");
    check(strobe_bits_out === (24'hff_ff23 & dpsp_pkg::OPEN_STROBE_MASK), "open strobes");
    check(mode_out === dpsp_pkg::MODE_OPEN, "soft reset changed mode");
  endtask

  initial begin
    rst = 1'b1;
    lock = 1'b0;
    fails = 0;
    n_compared = 0;
    cyc = 0;
    n_cfg = 0;
    n_srst = 0;
    n_stb = 0;
    b_stb = 0;
    t_legacy_select();
    t_legacy_reg0();
    t_legacy_read();
    t_open_read();
    t_open_write();
    end_sim();
  end
endmodule
